// ### bench/steer_far_side_model.sv
// Far side model: speed sensor, wheel sensor and valve actuator.
// Assumes the bench sets targets; sensors refresh at the falling edge.
`timescale 1ns/1ps
module steer_far_side_model (
  input wire logic core_clk, // Core clock
  input wire logic [15:0] speedSet, // Speed to report, 0.1 km/h
  input wire logic [15:0] rpmTenths, // Signed wheel rate, 0.1 rpm
  input wire logic [15:0] flowOut, // Conditioned flow from block
  input wire logic spoolNeutral, // Spool parked
  input wire logic bridgeEnable, // Bridge powered
  output logic [15:0] speedOut, // Speed sensor output
  output logic [12:0] wheelDelta, // Wheel change, dx units
  output logic [15:0] valveFlow // Flow the valve delivers
);
  logic signed [15:0] dxWide; // Rate in dx units
  // ---------------------------------------------------------------
  // Sensors
  // ---------------------------------------------------------------
  // One dx unit per 1.4 rpm of wheel rate
  assign dxWide = $signed(rpmTenths) / 16'sh000E;
  // Sensor values start at zero, then refresh once a cycle
  initial begin
    speedOut = 16'h0000;
    wheelDelta = 13'h0000;
    forever begin
      @(negedge core_clk);
      speedOut <= speedSet;
      wheelDelta <= dxWide[12:0];
    end
  end
  // ---------------------------------------------------------------
  // Actuator
  // ---------------------------------------------------------------
  // No flow with bridge off or spool parked
  assign valveFlow = (bridgeEnable && !spoolNeutral) ? flowOut
                     : 16'h0000;
endmodule

// ### bench/steering_flow_conditioner_tb.sv
// Testbench for the steering flow conditioner.
// Assumes a 10-cycle ms tick and the far side model beside it.
`timescale 1ns/1ps
module steering_flow_conditioner_tb;
  logic core_clk = 1'b0; // Core clock
  logic nrst = 1'b0; // Reset, active low
  logic [15:0] flowCmd = 16'h0000; // Flow command
  logic [14:0] neutralDelay = 15'h0003; // Neutral delay, ms
  logic [6:0] flowDeadband = 7'h00; // Dead-band, zero for tight loop
  logic [1:0] sensSelect = steering_flow_pkg::SEL_FIXED; // Selector
  logic [10:0] grad [6] = '{11'h1F4, 11'h3E8, 11'h320, 11'h258, 11'h190,
    11'h0C8}; // Non-increasing from point 1; standstill entry 500 sits below it
  logic [9:0] speedSpan = 10'h0A0; // 16.0 km/h span
  logic [15:0] speedSet = 16'h0000; // Speed asked of sensor
  logic [15:0] rpmTenths = 16'h0000; // Wheel rate asked of sensor
  logic speedMapped = 1'b1; // Speed source present
  logic speedFaultTolerated = 1'b0; // Speed fault flag
  logic [14:0] bridgeOffDelay = 15'h0032; // 50 ms off delay
  logic wheelCheckEnable = 1'b1; // Movement check on
  logic [11:0] moveThr = 12'h005; // Wheel change threshold
  logic [30:0] engTimeout = 31'h00000002; // Grace window, ms
  logic engageRequest = 1'b0; // Engage ask
  logic [15:0] speedVal, flowOut, valveFlow; // Speed, flows
  logic [12:0] wheelDelta; // Wheel change
  logic [10:0] gradActive; // Gradient in use
  logic spoolNeutral, bridgeEnable, engageAllowed, autoEngaged; // Flags
  int fails = 0; // Mismatch count
  int checks_done = 0; // Comparison count
  // Clock, 20 ns period
  always #10 core_clk = ~core_clk;
  steering_flow_conditioner #(.TICK_CYCLES(10)) steering_flow_conditioner_i (
    .core_clk(core_clk), .nrst(nrst), .flowCmd(flowCmd),
    .neutralDelay(neutralDelay), .flowDeadband(flowDeadband),
    .sensSelect(sensSelect), .gradient_standstill(grad[0]),
    .gradient_point_1(grad[1]), .gradient_point_2(grad[2]),
    .gradient_point_3(grad[3]), .gradient_point_4(grad[4]),
    .gradient_point_5(grad[5]), .speedSpan(speedSpan),
    .vehicle_speed_value(speedVal), .speedMapped(speedMapped),
    .speedFaultTolerated(speedFaultTolerated),
    .bridgeOffDelay(bridgeOffDelay), .wheelCheckEnable(wheelCheckEnable),
    .wheelDelta(wheelDelta), .wheel_move_threshold(moveThr),
    .engage_window_timeout(engTimeout), .engageRequest(engageRequest),
    .flowOut(flowOut), .spoolNeutral(spoolNeutral),
    .bridgeEnable(bridgeEnable), .gradActive(gradActive),
    .engageAllowed(engageAllowed), .autoEngaged(autoEngaged));
  steer_far_side_model steer_far_side_model_i (
    .core_clk(core_clk), .speedSet(speedSet), .rpmTenths(rpmTenths),
    .flowOut(flowOut), .spoolNeutral(spoolNeutral),
    .bridgeEnable(bridgeEnable), .speedOut(speedVal),
    .wheelDelta(wheelDelta), .valveFlow(valveFlow));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Wait n falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Compare one flag
  task automatic bchk(input logic got, input logic exp, input string what);
    chk({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  // Present a speed and check the gradient chosen
  task automatic spd(input logic [15:0] v, input logic m, input logic f,
      input logic [10:0] g);
    speedSet = v;
    speedMapped = m;
    speedFaultTolerated = f;
    cyc(6);
    chk({5'h00, gradActive}, {5'h00, g}, "speed gradient");
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100us;
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    cyc(4);
    chk(flowOut, 16'h0000, "reset flow");
    bchk(bridgeEnable, 1'b1, "reset bridge");
    chk({5'h00, gradActive}, 16'h03E8, "reset gradient");
    bchk(engageAllowed, 1'b0, "reset gate");
    cyc(1);
    nrst = 1'b1;
    // Fixed sensitivity, both signs
    flowCmd = 16'h00C8;
    cyc(3);
    chk({5'h00, gradActive}, 16'h01F4, "fixed gradient");
    chk(flowOut, 16'h0064, "fixed flow");
    flowCmd = 16'hFF38;
    cyc(3);
    chk(flowOut, 16'hFF9C, "fixed negative flow");
    // Neutral dwell and release
    flowDeadband = 7'h0A;
    flowCmd = 16'h0005;
    cyc(18);
    bchk(spoolNeutral, 1'b0, "early neutral");
    cyc(27);
    bchk(spoolNeutral, 1'b1, "neutral after dwell");
    chk(flowOut, 16'h0000, "neutral flow");
    flowCmd = 16'h0014;
    cyc(2);
    bchk(spoolNeutral, 1'b0, "leave neutral");
    cyc(1);
    chk(flowOut, 16'h000A, "flow after neutral");
    // Bridge off delay and wake-up
    flowCmd = 16'h0000;
    cyc(480);
    bchk(bridgeEnable, 1'b1, "early bridge off");
    cyc(50);
    bchk(bridgeEnable, 1'b0, "bridge off");
    chk(valveFlow, 16'h0000, "valve flow off");
    flowCmd = 16'h0001;
    cyc(2);
    bchk(bridgeEnable, 1'b1, "bridge wake");
    bridgeOffDelay = steering_flow_pkg::BRIDGE_OFF_NEVER;
    flowCmd = 16'h0000;
    cyc(600);
    bchk(bridgeEnable, 1'b1, "bridge never off");
    // Speed dependent sensitivity
    grad[0] = 11'h4B0;
    sensSelect = steering_flow_pkg::SEL_SPEED;
    flowCmd = 16'h00C8;
    spd(16'h0000, 1'b1, 1'b0, 11'h4B0);
    spd(16'h000A, 1'b1, 1'b0, 11'h3E8);
    spd(16'h000F, 1'b1, 1'b0, 11'h384);
    chk(flowOut, 16'h00B4, "speed flow");
    spd(16'hFFC4, 1'b1, 1'b0, 11'h1F4);
    spd(16'h00A0, 1'b1, 1'b0, 11'h0C8);
    spd(16'h003C, 1'b0, 1'b0, 11'h4B0);
    spd(16'h003C, 1'b1, 1'b1, 11'h0C8);
    // Wheel movement gate
    engageRequest = 1'b1;
    rpmTenths = 16'h0046;
    cyc(7);
    bchk(autoEngaged, 1'b0, "engage at threshold");
    rpmTenths = 16'hFFAC;
    cyc(7);
    bchk(autoEngaged, 1'b1, "engage after move");
    engageRequest = 1'b0;
    rpmTenths = 16'h0000;
    cyc(5);
    engageRequest = 1'b1;
    cyc(2);
    bchk(autoEngaged, 1'b1, "engage in window");
    engageRequest = 1'b0;
    cyc(40);
    bchk(engageAllowed, 1'b0, "window expired");
    engageRequest = 1'b1;
    cyc(3);
    bchk(autoEngaged, 1'b0, "engage refused");
    engageRequest = 1'b0;
    engTimeout = steering_flow_pkg::ENGAGE_OFF;
    wheelCheckEnable = 1'b0;
    cyc(1);
    bchk(engageAllowed, 1'b1, "check off");
    wheelCheckEnable = 1'b1;
    rpmTenths = 16'hFFAC;
    cyc(7);
    rpmTenths = 16'h0000;
    cyc(100);
    bchk(engageAllowed, 1'b1, "window never ends");
    report_and_stop();
  end
endmodule

// ### pkg/steering_flow_pkg.sv
// Constants and types shared by the steering flow conditioner.
// Assumes a 50 MHz core clock; all settings arrive as plain ports.
package steering_flow_pkg;

  // ---------------------------------------------------------------
  // Clock and tick
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50000000;       // Core clock rate
  localparam int TICK_MS = 1;             // Tick period in ms
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS; // Cycles per ms

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int FLOW_W = 16;             // Signed flow command width
  localparam int GRAD_W = 11;             // Gradient setting width
  localparam int SPEED_W = 16;            // Signed speed width
  localparam int MS_W = 31;               // Millisecond timer width
  localparam int DX_W = 13;               // Signed wheel change width

  // ---------------------------------------------------------------
  // Reset values and limits of settings
  // ---------------------------------------------------------------
  localparam logic [14:0] NEUTRAL_DELAY_RST = 15'h0BB8;  // 3000 ms
  localparam logic [14:0] NEUTRAL_DELAY_MAX = 15'h7530;  // 30000 ms
  localparam logic [6:0] DEADBAND_RST = 7'h00;           // 0.0 %
  localparam logic [6:0] DEADBAND_MAX = 7'h64;           // 10.0 %
  localparam logic [10:0] GRAD_BASE_RST = 11'h3E8;       // Full scale
  localparam logic [10:0] GRAD_FULL = 11'h3E8;           // Divisor 1000
  localparam logic [9:0] SPAN_RST = 10'h1F4;             // 50.0 km/h
  localparam logic [9:0] SPAN_MAX = 10'h3E8;             // 100.0 km/h
  localparam logic [14:0] BRIDGE_OFF_RST = 15'h7530;     // 30000 ms
  localparam logic [14:0] BRIDGE_OFF_NEVER = 15'h7530;   // Always on
  localparam logic [11:0] MOVE_THR_RST = 12'h005;        // 5 dx units
  localparam logic [30:0] ENGAGE_OFF = 31'h7FFFFFFF;     // Window never expires

  // ---------------------------------------------------------------
  // Sensitivity selector values
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_FIXED = 2'h1;  // Fixed sensitivity
  localparam logic [1:0] SEL_SPEED = 2'h3;  // Speed dependent

  // Speed breakpoint shifts of the span: /16, /8, /4, /2, /1
  localparam int BP1_SH = 4;
  localparam int BP2_SH = 3;
  localparam int BP3_SH = 2;
  localparam int BP4_SH = 1;

  // Engage gate state
  typedef enum logic [1:0] {
    GATE_BLOCK = 2'b00,   // Movement not yet seen
    GATE_MOVE = 2'b01,    // Movement above threshold
    GATE_WINDOW = 2'b10   // Grace window after movement
  } gate_state_t;

endpackage

// ### rtl/ms_tick_gen.sv
// Millisecond tick generator.
// Assumes the core clock rate given in the package.
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int CYCLES = steering_flow_pkg::TICK_CYCLES // Cycles per tick
) (
  input wire logic core_clk, // Core clock
  input wire logic nrst,     // Async reset, active low
  output logic tick          // One-cycle pulse per ms
);

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q; // Cycle count within the ms
  logic [CW-1:0] cnt_d; // Next count
  logic tick_d;         // Wrap flag

  assign tick_d = (cnt_q == LAST);
  assign cnt_d = tick_d ? '0 : cnt_q + 1'b1;

  // Counter and registered pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= tick_d;
    end
  end

endmodule

// ### rtl/speed_gradient_interp.sv
// Speed to gradient interpolation over six breakpoints.
// Assumes a monotone, non-increasing table from the configuring party.
`timescale 1ns/1ps
module speed_gradient_interp (
  input wire logic core_clk,              // Core clock
  input wire logic nrst,                  // Async reset, active low
  input wire logic [15:0] speedMag,       // Speed magnitude, 0.1 km/h
  input wire logic [9:0] speedSpan,       // Span setting, 0.1 km/h
  input wire logic [65:0] gradTable,      // Six gradients, point 0 low
  output logic [10:0] gradOut             // Interpolated gradient
);

  // ---------------------------------------------------------------
  // Breakpoint selection
  // ---------------------------------------------------------------
  logic [15:0] bp [6];     // Speed breakpoints
  logic [10:0] g [6];      // Gradients at breakpoints
  logic [2:0] seg;         // Segment index, 5 means beyond span
  logic [15:0] lo, hi;     // Segment speed bounds
  logic [10:0] gLo, gHi;   // Segment gradients
  logic [15:0] span16;     // Span widened
  logic [26:0] num;        // Drop times offset
  logic [10:0] drop;       // Gradient drop over segment
  logic [10:0] step;       // Interpolated drop
  logic [10:0] grad_d;     // Next output

  assign span16 = {6'h00, speedSpan};
  assign bp[0] = 16'h0000;
  assign bp[1] = span16 >> steering_flow_pkg::BP1_SH;
  assign bp[2] = span16 >> steering_flow_pkg::BP2_SH;
  assign bp[3] = span16 >> steering_flow_pkg::BP3_SH;
  assign bp[4] = span16 >> steering_flow_pkg::BP4_SH;
  assign bp[5] = span16;

  for (genvar i = 0; i < 6; i++) begin : g_tab
    assign g[i] = gradTable[i*11 +: 11];
  end

  // Find the segment the speed falls in
  always_comb begin
    seg = 3'h5;
    for (int k = 4; k >= 0; k--) begin
      if (speedMag < bp[k+1]) begin
        seg = 3'(k);
      end
    end
  end

  assign lo = (seg == 3'h5) ? bp[5] : bp[seg];
  assign hi = (seg == 3'h5) ? bp[5] : bp[seg + 3'h1];
  assign gLo = (seg == 3'h5) ? g[5] : g[seg];
  assign gHi = (seg == 3'h5) ? g[5] : g[seg + 3'h1];

  // Linear interpolation between neighbours
  assign drop = (gLo > gHi) ? gLo - gHi : 11'h000;
  assign num = 27'(drop) * 27'(speedMag - lo);
  assign step = (hi == lo) ? 11'h000 : 11'(num / 27'(hi - lo));
  assign grad_d = gLo - step; // RL9

  // Registered output
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gradOut <= steering_flow_pkg::GRAD_BASE_RST;
    end else begin
      gradOut <= grad_d;
    end
  end

endmodule

// ### rtl/steering_flow_conditioner.sv
// Port flow conditioner: neutral dwell, sensitivity, bridge off,
// and wheel movement gate for auto-steering engagement.
// Assumes settings held stable by the configuring party.
//
// Functional notes
// (RL1) Neutral spool after dead-band dwell time
// (RL2) Leave neutral once flow exceeds dead-band
// (RL3) Neutral delay 1 to 30000 ms, default 3000
// (RL4) Dead-band 0 to 100 tenths percent, default 0
// (RL5) Selector 1 gives fixed sensitivity
// (RL6) Fixed mode scales flow by base gradient
// (RL7) Selector 3 gives speed dependent sensitivity
// (RL8) Breakpoints at 0, 6.25..100 percent span
// (RL9) Interpolate gradient linearly between breakpoints
// (RL10) Negative speeds use speed magnitude
// (RL11) Unmapped speed source keeps speed zero
// (RL12) Table set 20..1200, non-increasing with speed
// (RL13) Speed span 1 to 1000, default 500
// (RL14) Bridge off after zero-flow delay elapses
// (RL15) Non-zero flow re-enables bridge immediately
// (RL16) Without wheel sensor use 50..200 ms delay
// (RL17) Engage refused until wheel change exceeds threshold
// (RL18) One change unit means 1.4 rpm
// (RL19) Grace window after movement; all-ones disables
// (RL20) Integrator should enable the disengage check
// (RL21) Dead-band zero for tight closed loop
// (RL22) Tolerated speed fault assumes maximum speed
// (RL23) Timers count ms ticks, clear when unmet
`timescale 1ns/1ps
module steering_flow_conditioner #(
  parameter int TICK_CYCLES = steering_flow_pkg::TICK_CYCLES // Cycles/ms
) (
  input wire logic core_clk,                 // Core clock
  input wire logic nrst,                     // Async reset, active low
  input wire logic [15:0] flowCmd,           // Signed port flow command
  input wire logic [14:0] neutralDelay,      // Neutral delay, ms
  input wire logic [6:0] flowDeadband,       // Dead-band, 0.1 % units
  input wire logic [1:0] sensSelect,         // Sensitivity selector
  input wire logic [10:0] gradient_standstill, // Gradient at standstill
  input wire logic [10:0] gradient_point_1,  // Gradient at 6.25 %
  input wire logic [10:0] gradient_point_2,  // Gradient at 12.5 %
  input wire logic [10:0] gradient_point_3,  // Gradient at 25 %
  input wire logic [10:0] gradient_point_4,  // Gradient at 50 %
  input wire logic [10:0] gradient_point_5,  // Gradient at 100 %
  input wire logic [9:0] speedSpan,          // Speed span, 0.1 km/h
  input wire logic [15:0] vehicle_speed_value, // Signed speed, 0.1 km/h
  input wire logic speedMapped,              // Speed source present
  input wire logic speedFaultTolerated,      // Speed fault, reduced state
  input wire logic [14:0] bridgeOffDelay,    // Bridge off delay, ms
  input wire logic wheelCheckEnable,         // Movement check on
  input wire logic [12:0] wheelDelta,        // Signed wheel change dx
  input wire logic [11:0] wheel_move_threshold, // Change threshold
  input wire logic [30:0] engage_window_timeout, // Grace window, ms
  input wire logic engageRequest,            // Auto-steer engage ask
  output logic [15:0] flowOut,               // Conditioned flow command
  output logic spoolNeutral,                 // Spool held in neutral
  output logic bridgeEnable,                 // Magnetic bridge enable
  output logic [10:0] gradActive,            // Gradient in use
  output logic engageAllowed,                // Engagement permitted
  output logic autoEngaged                   // Auto-steering engaged
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Magnitude of a signed 16-bit value
  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? 16'(-v) : v;
  endfunction

  // Saturating ms counter step
  function automatic logic [30:0] msStep(input logic [30:0] c,
                                         input logic t);
    msStep = (t && c != 31'h7FFFFFFF) ? c + 31'h00000001 : c;
  endfunction

  logic tick; // Millisecond strobe

  ms_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) ms_tick_gen_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Neutral dwell
  // ---------------------------------------------------------------
  logic [15:0] flowMag;     // Command magnitude
  logic [25:0] bandProd;    // Dead-band scaled to full scale
  logic [15:0] bandLimit;   // Dead-band in command units
  logic [6:0] bandClamp;    // Dead-band held to range
  logic [14:0] nDelayEff;   // Neutral delay held to range
  logic inBand;             // Command inside dead-band
  logic [30:0] nCnt_q, nCnt_d; // Dwell timer
  logic neutral_q, neutral_d;  // Neutral state

  // Full command scale is 1000 units; dead-band units are 0.1 %
  assign flowMag = mag16(flowCmd);
  assign bandClamp = (flowDeadband > steering_flow_pkg::DEADBAND_MAX) ?
                     steering_flow_pkg::DEADBAND_MAX : flowDeadband; // RL4
  assign bandProd = 26'(bandClamp);
  assign bandLimit = bandProd[15:0];
  assign inBand = (flowMag <= bandLimit);
  assign nDelayEff = (neutralDelay == 15'h0000) ? 15'h0001 :
                     (neutralDelay > steering_flow_pkg::NEUTRAL_DELAY_MAX) ?
                     steering_flow_pkg::NEUTRAL_DELAY_MAX : neutralDelay; // RL3

  // Timer runs only while inside the band
  assign nCnt_d = inBand ? msStep(nCnt_q, tick) : 31'h00000000; // RL23
  assign neutral_d = !inBand ? 1'b0 : // RL2
                     (nCnt_q >= 31'(nDelayEff)) ? 1'b1 : neutral_q; // RL1

  // Dwell timer and neutral flag
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nCnt_q <= 31'h00000000;
      neutral_q <= 1'b0;
    end else begin
      nCnt_q <= nCnt_d;
      neutral_q <= neutral_d;
    end
  end

  a_neutral_leave: assert property ( // RL2
    @(posedge core_clk) disable iff (!nrst)
    !inBand |=> !neutral_q) else $error("spool stayed neutral");
  a_neutral_dwell: assert property ( // RL1
    @(posedge core_clk) disable iff (!nrst)
    $rose(neutral_q) |-> $past(nCnt_q) >= 31'($past(nDelayEff)))
    else $error("neutral entered early");

  // ---------------------------------------------------------------
  // Sensitivity
  // ---------------------------------------------------------------
  logic [15:0] speedMag;    // Speed magnitude used
  logic [15:0] speedIn;     // Raw magnitude
  logic [9:0] spanEff;      // Span held to range
  logic [10:0] gradSpeed;   // Interpolated gradient
  logic [10:0] grad_d;      // Gradient selected
  logic [65:0] gradTable;   // Packed table

  assign speedIn = speedMapped ? // RL10 RL11
                   mag16(vehicle_speed_value) : 16'h0000;
  assign spanEff = (speedSpan == 10'h000) ? 10'h001 :
                   (speedSpan > steering_flow_pkg::SPAN_MAX) ?
                   steering_flow_pkg::SPAN_MAX : speedSpan; // RL13
  assign speedMag = speedFaultTolerated ? 16'hFFFF : speedIn; // RL22
  assign gradTable = {gradient_point_5, gradient_point_4, gradient_point_3,
                      gradient_point_2, gradient_point_1,
                      gradient_standstill}; // RL8

  speed_gradient_interp speed_gradient_interp_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .speedMag(speedMag),
    .speedSpan(spanEff),
    .gradTable(gradTable),
    .gradOut(gradSpeed)
  );

  // Fixed mode uses the base gradient; other codes fall back to it
  assign grad_d = (sensSelect == steering_flow_pkg::SEL_SPEED) ?
                  gradSpeed : gradient_standstill; // RL5 RL7

  // Scaled command: flow times gradient over full scale
  logic signed [27:0] scaled;   // Product over 1000
  logic signed [15:0] flow_d;   // Next output flow
  assign scaled = 28'(($signed(flowCmd) * $signed({1'b0, gradActive}))
                  / $signed({17'h00000, steering_flow_pkg::GRAD_FULL}));
  assign flow_d = neutral_q ? 16'sh0000 :
                  (scaled > 28'sh0007FFF) ? 16'sh7FFF :
                  (scaled < -28'sh0008000) ? -16'sh8000 :
                  16'(scaled); // RL6

  // Gradient and flow registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gradActive <= steering_flow_pkg::GRAD_BASE_RST;
      flowOut <= 16'h0000;
    end else begin
      gradActive <= grad_d;
      flowOut <= flow_d;
    end
  end

  assign spoolNeutral = neutral_q;

  a_fixed_grad: assert property ( // RL5
    @(posedge core_clk) disable iff (!nrst)
    sensSelect == steering_flow_pkg::SEL_FIXED |=>
    gradActive == $past(gradient_standstill))
    else $error("fixed gradient not used");
  a_neutral_flow: assert property ( // RL1
    @(posedge core_clk) disable iff (!nrst)
    neutral_q |=> flowOut == 16'h0000)
    else $error("flow while neutral");

  // ---------------------------------------------------------------
  // Magnetic bridge
  // ---------------------------------------------------------------
  logic zeroFlow;               // No flow requested
  logic bridgeTimed;            // Off function in use
  logic [30:0] bCnt_q, bCnt_d;  // Zero-flow timer
  logic bridge_q, bridge_d;     // Bridge enable state

  assign zeroFlow = (flowCmd == 16'h0000);
  assign bridgeTimed = (bridgeOffDelay < steering_flow_pkg::BRIDGE_OFF_NEVER);
  assign bCnt_d = zeroFlow ? msStep(bCnt_q, tick) : 31'h00000000; // RL23
  assign bridge_d = !zeroFlow ? 1'b1 : // RL15
                    (bridgeTimed && bCnt_q >= 31'(bridgeOffDelay) &&
                     bridgeOffDelay != 15'h0000) ? 1'b0 : bridge_q; // RL14

  // Bridge timer and enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bCnt_q <= 31'h00000000;
      bridge_q <= 1'b1;
    end else begin
      bCnt_q <= bCnt_d;
      bridge_q <= bridge_d;
    end
  end

  assign bridgeEnable = bridge_q;

  a_bridge_on: assert property ( // RL15
    @(posedge core_clk) disable iff (!nrst)
    !zeroFlow |=> bridgeEnable) else $error("bridge not re-enabled");
  a_bridge_never: assert property ( // RL14
    @(posedge core_clk) disable iff (!nrst)
    !bridgeTimed && $past(bridge_q) |-> bridge_q)
    else $error("bridge off at default");

  // ---------------------------------------------------------------
  // Wheel movement gate
  // ---------------------------------------------------------------
  // One dx unit equals 1.4 rpm; threshold compared in dx units
  logic [12:0] dxMag;                  // Change magnitude
  logic [12:0] dx_s1_q, dx_s2_q;       // Sync stages for sensor data
  logic moving;                        // Above threshold
  logic windowOff;                     // Timeout disables window expiry
  logic [30:0] wCnt_q, wCnt_d;         // Grace window timer
  steering_flow_pkg::gate_state_t st_q, st_d; // Gate state
  logic engaged_q, engaged_d;          // Auto-steer engaged

  assign dxMag = dx_s2_q[12] ? 13'(-dx_s2_q) : dx_s2_q; // RL18
  assign moving = (dxMag > {1'b0, wheel_move_threshold}); // RL17
  assign windowOff = (engage_window_timeout == steering_flow_pkg::ENGAGE_OFF);
  assign wCnt_d = (st_q == steering_flow_pkg::GATE_WINDOW) ?
                  msStep(wCnt_q, tick) : 31'h00000000; // RL23

  // Gate state transitions
  always_comb begin
    st_d = st_q;
    case (st_q)
      steering_flow_pkg::GATE_BLOCK: begin
        if (moving) st_d = steering_flow_pkg::GATE_MOVE;
      end
      steering_flow_pkg::GATE_MOVE: begin
        if (!moving) st_d = steering_flow_pkg::GATE_WINDOW;
      end
      steering_flow_pkg::GATE_WINDOW: begin
        if (moving) begin
          st_d = steering_flow_pkg::GATE_MOVE;
        end else if (!windowOff && wCnt_q >= engage_window_timeout) begin
          st_d = steering_flow_pkg::GATE_BLOCK; // RL19
        end
      end
      default: st_d = steering_flow_pkg::GATE_BLOCK;
    endcase
  end

  assign engageAllowed = !wheelCheckEnable ||
                         (st_q != steering_flow_pkg::GATE_BLOCK); // RL17
  assign engaged_d = engageRequest && (engaged_q || engageAllowed);

  // Sync, gate and engagement registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dx_s1_q <= 13'h0000;
      dx_s2_q <= 13'h0000;
      wCnt_q <= 31'h00000000;
      st_q <= steering_flow_pkg::GATE_BLOCK;
      engaged_q <= 1'b0;
    end else begin
      dx_s1_q <= wheelDelta;
      dx_s2_q <= dx_s1_q;
      wCnt_q <= wCnt_d;
      st_q <= st_d;
      engaged_q <= engaged_d;
    end
  end

  assign autoEngaged = engaged_q;

  a_engage_block: assert property ( // RL17
    @(posedge core_clk) disable iff (!nrst)
    wheelCheckEnable && st_q == steering_flow_pkg::GATE_BLOCK && !engaged_q
    |=> !engaged_q) else $error("engaged without movement");
  a_window_hold: assert property ( // RL19
    @(posedge core_clk) disable iff (!nrst)
    windowOff && st_q == steering_flow_pkg::GATE_WINDOW && !moving
    |=> st_q == steering_flow_pkg::GATE_WINDOW)
    else $error("window expired while disabled");

endmodule
